//--- rtl/sscc_pkg.sv
// Constants and types of the spread-spectrum clock control block
package sscc_pkg;
	localparam int CLK_MHZ           = 100;
	localparam int POR_US            = 40;
	localparam int POR_CYCLES        = POR_US * CLK_MHZ;
	localparam int PDN_OFF_NS        = 7000;
	localparam int PDN_OFF_CYCLES    = (PDN_OFF_NS * CLK_MHZ) / 1000;
	localparam int NV_WRITE_MS       = 10;
	localparam int NV_WRITE_CYCLES   = NV_WRITE_MS * CLK_MHZ * 1000;
	localparam int NV_CNT_W          = 24;
	localparam int SETTLE_OSC_CYCLES = 512;
	localparam int MOSC_HALF_CYCLES  = 100;
	localparam int DITHER_UNIT       = MOSC_HALF_CYCLES / 100;
	localparam int DITHER_DIV_BASE   = 2048;
	localparam int PRESC_MAX_EXP     = 8;
	localparam int PS_RATE_LSB       = 6;
	localparam int PS_DRIVE_LOW_BIT  = 5;
	localparam int PS_DIV_LSB        = 0;
	localparam int AD_PCT_LSB        = 6;
	localparam int AD_SW_OFF_BIT     = 5;
	localparam int AD_DEFER_BIT      = 3;
	localparam int AD_SEL_LSB        = 0;
	localparam logic [7:0] REG_WMASK     = 8'hef;
	localparam logic [7:0] PRESCALER_RST = 8'h00;
	localparam logic [7:0] ADDR_RST      = 8'h00;
	localparam logic [7:0] CMD_PRESCALER = 8'h02;
	localparam logic [7:0] CMD_ADDR      = 8'h0d;
	localparam logic [7:0] CMD_WRITE_NV  = 8'h3f;
	localparam logic [3:0] SLAVE_ADDR_HI = 4'hb;

	typedef enum logic [3:0] {
		ST_POR  = 4'h1,
		ST_WARM = 4'h2,
		ST_RUN  = 4'h4,
		ST_PDN  = 4'h8
	} sscc_pwr_type;

	typedef enum logic [8:0] {
		B_IDLE  = 9'h001,
		B_ADDR  = 9'h002,
		B_AACK  = 9'h004,
		B_REG   = 9'h008,
		B_RGACK = 9'h010,
		B_WDATA = 9'h020,
		B_WACK  = 9'h040,
		B_RDATA = 9'h080,
		B_RACK  = 9'h100
	} sscc_bus_type;
endpackage

//--- rtl/sscc_top.sv
// Spread-spectrum clock control: power sequencing, dither, prescaler and serial slave
`timescale 1ns/1ps
module sscc_top #(
	parameter int NV_WRITE_CYCLES = sscc_pkg::NV_WRITE_CYCLES
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic dither_enable_pin_i,
	input  wire logic output_enable_pin_i,
	input  wire logic power_down_pin_n_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output wire logic sda_o,
	output wire logic sda_oe_o,
	output wire logic clk_out_o,
	output wire logic clk_out_oe_o,
	output wire logic osc_run_o,
	output wire logic nv_write_start_o,
	output wire logic nv_busy_o
);
	typedef struct packed {
		sscc_pkg::sscc_pwr_type pwr;
		logic [11:0]            cnt;
		logic [9:0]             pdn_cnt;
		logic [4:0]             sync1;
		logic [4:0]             sync2;
		logic                   scl_d;
		logic                   sda_d;
		logic                   osc_lvl;
		logic [7:0]             osc_cnt;
		logic [12:0]            ph;
		logic [7:0]             div_cnt;
		logic                   out_lvl;
		logic                   active;
		logic                   pin_lvl;
		logic                   pin_oe;
		logic [7:0]             presc;
		logic [7:0]             addr;
		sscc_pkg::sscc_bus_type bus;
		logic [3:0]             bits;
		logic [7:0]             sh;
		logic [7:0]             ptr;
		logic                   rw;
		logic                   nack;
		logic                   sda_drv;
		logic                   nv_pend;
		logic                   nv_busy;
		logic                   nv_go;
		logic [sscc_pkg::NV_CNT_W-1:0] nv_cnt;
	} sscc_state_type;

	localparam sscc_state_type S_RST = '{
		pwr: sscc_pkg::ST_POR,
		bus: sscc_pkg::B_IDLE,
		presc: sscc_pkg::PRESCALER_RST,
		addr: sscc_pkg::ADDR_RST,
		default: '0
	};
	localparam logic [sscc_pkg::NV_CNT_W-1:0] NV_LAST = sscc_pkg::NV_CNT_W'(NV_WRITE_CYCLES - 1);

	sscc_state_type s_reg;
	sscc_state_type s_next;

	logic               scl;
	logic               sda;
	logic               scl_rise;
	logic               scl_fall;
	logic               start;
	logic               stop;
	logic [1:0]         rate;
	logic [1:0]         pct;
	logic [3:0]         exp_sel;
	logic [7:0]         lim;
	logic               dith_on;
	logic [7:0]         p8;
	logic [9:0]         tri_u;
	logic signed [14:0] prod;
	logic [14:0]        mag;
	logic [9:0]         off;
	logic [9:0]         half;
	logic [3:0]         amp;
	logic [12:0]        ph_max;
	logic               osc_edge;
	logic               osc_rise;
	logic               en;
	logic [7:0]         rd;
	logic               wr_take;
	logic [6:0]         my_addr;

	// Bus lines pass two flops; 100 MHz oversampling covers 400 kHz and slower
	assign scl      = s_reg.sync2[0];
	assign sda      = s_reg.sync2[1];
	assign scl_rise = scl & ~s_reg.scl_d;
	assign scl_fall = ~scl & s_reg.scl_d;
	assign start    = scl & s_reg.scl_d & s_reg.sda_d & ~sda;
	assign stop     = scl & s_reg.scl_d & ~s_reg.sda_d & sda;

	assign rate    = s_reg.presc[sscc_pkg::PS_RATE_LSB +: 2];
	assign pct     = s_reg.addr[sscc_pkg::AD_PCT_LSB +: 2];
	assign my_addr = {sscc_pkg::SLAVE_ADDR_HI, s_reg.addr[sscc_pkg::AD_SEL_LSB +: 3]};
	assign dith_on = s_reg.sync2[2] & (rate != 2'b00);

	always_comb begin
		exp_sel = s_reg.presc[sscc_pkg::PS_DIV_LSB +: 4];
		if (exp_sel > 4'(sscc_pkg::PRESC_MAX_EXP))
			exp_sel = 4'(sscc_pkg::PRESC_MAX_EXP);
		lim    = 8'((9'd1 << exp_sel) - 9'd1);
		ph_max = 13'((sscc_pkg::DITHER_DIV_BASE << (rate - 2'd1)) - 1);
		p8     = 8'(s_reg.ph >> (3'(rate) + 3'd2));
		// Triangle from -128 to +128; rising slope -128 to +126, falling slope +128 to -126
		tri_u  = p8[7] ? 10'd384 - {1'b0, p8, 1'b0} : {1'b0, p8, 1'b0} - 10'd128;
		amp    = 4'(sscc_pkg::DITHER_UNIT << pct);
		prod   = $signed({{5{tri_u[9]}}, tri_u}) * $signed({11'd0, amp});
		mag    = prod[14] ? 15'(-prod) : 15'(prod);
		// Magnitude is truncated before the sign so both swings match
		off    = prod[14] ? 10'(-(mag >> 7)) : 10'(mag >> 7);
		if (!dith_on)
			off = '0;
		half     = 10'(sscc_pkg::MOSC_HALF_CYCLES) + off;
		osc_edge = (s_reg.pwr != sscc_pkg::ST_PDN) & ({2'b00, s_reg.osc_cnt} >= half - 10'd1);
		osc_rise = osc_edge & ~s_reg.osc_lvl;
		en       = (s_reg.pwr == sscc_pkg::ST_RUN)
			& (s_reg.sync2[3] | ~s_reg.addr[sscc_pkg::AD_SW_OFF_BIT]);
		if (s_reg.ptr == sscc_pkg::CMD_PRESCALER)
			rd = s_reg.presc;
		else if (s_reg.ptr == sscc_pkg::CMD_ADDR)
			rd = s_reg.addr;
		else
			rd = 8'h00;
		wr_take = ~start & ~stop & scl_fall & (s_reg.bus == sscc_pkg::B_WDATA)
			& (s_reg.bits == 4'h8);
	end

	always_comb begin
		s_next       = s_reg;
		s_next.nv_go = 1'b0;
		s_next.sync1 = {power_down_pin_n_i, output_enable_pin_i, dither_enable_pin_i, sda_i, scl_i};
		s_next.sync2 = s_reg.sync1;
		s_next.scl_d = scl;
		s_next.sda_d = sda;

		// Master oscillator model; stopped in power-down
		if (s_reg.pwr == sscc_pkg::ST_PDN) begin
			s_next.osc_cnt = '0;
			s_next.osc_lvl = 1'b0;
		end else if (osc_edge) begin
			s_next.osc_cnt = '0;
			s_next.osc_lvl = ~s_reg.osc_lvl;
		end else begin
			s_next.osc_cnt = s_reg.osc_cnt + 8'h01;
		end
		if (osc_rise)
			s_next.ph = (s_reg.ph >= ph_max) ? '0 : s_reg.ph + 13'd1;

		// Output divider; the limit is re-read at every edge
		if (s_reg.pwr == sscc_pkg::ST_PDN) begin
			s_next.div_cnt = '0;
			s_next.out_lvl = 1'b0;
		end else if (osc_edge) begin
			if (s_reg.div_cnt >= lim) begin
				s_next.div_cnt = '0;
				// Divide by one follows the master level, so both halves share one dither step
				s_next.out_lvl = (lim == 8'h00) ? ~s_reg.osc_lvl : ~s_reg.out_lvl;
			end else begin
				s_next.div_cnt = s_reg.div_cnt + 8'h01;
			end
		end

		// Outside power-down the gate changes only while the divided clock is low, so no runt pulses
		if (s_reg.pwr == sscc_pkg::ST_PDN)
			s_next.active = 1'b0;
		else if (!s_reg.out_lvl)
			s_next.active = en;
		s_next.pin_lvl = s_next.out_lvl & s_next.active;
		s_next.pin_oe  = s_next.active | s_reg.presc[sscc_pkg::PS_DRIVE_LOW_BIT];

		// Power sequencing
		if (s_reg.sync2[4] || s_reg.pwr == sscc_pkg::ST_PDN)
			s_next.pdn_cnt = '0;
		else
			s_next.pdn_cnt = s_reg.pdn_cnt + 10'd1;
		unique case (s_reg.pwr)
			sscc_pkg::ST_POR: begin
				s_next.cnt = s_reg.cnt + 12'd1;
				if (s_reg.cnt == 12'(sscc_pkg::POR_CYCLES - 1)) begin
					s_next.pwr = sscc_pkg::ST_WARM;
					s_next.cnt = '0;
				end
			end
			sscc_pkg::ST_WARM: begin
				if (osc_rise) begin
					s_next.cnt = s_reg.cnt + 12'd1;
					if (s_reg.cnt == 12'(sscc_pkg::SETTLE_OSC_CYCLES - 1))
						s_next.pwr = sscc_pkg::ST_RUN;
				end
			end
			sscc_pkg::ST_RUN: begin
				s_next.cnt = '0;
			end
			sscc_pkg::ST_PDN: begin
				s_next.cnt = '0;
				if (s_reg.sync2[4])
					s_next.pwr = sscc_pkg::ST_WARM;
			end
		endcase
		if (s_reg.pwr != sscc_pkg::ST_PDN
				&& s_reg.pdn_cnt == 10'(sscc_pkg::PDN_OFF_CYCLES - 1)) begin
			s_next.pwr = sscc_pkg::ST_PDN;
			s_next.cnt = '0;
		end

		// Nonvolatile write timer
		if (s_reg.nv_busy) begin
			s_next.nv_cnt = s_reg.nv_cnt + 1'b1;
			if (s_reg.nv_cnt >= NV_LAST)
				s_next.nv_busy = 1'b0;
		end

		// Two-wire slave
		if (start) begin
			s_next.bus     = sscc_pkg::B_ADDR;
			s_next.bits    = '0;
			s_next.sda_drv = 1'b0;
		end else if (stop) begin
			s_next.bus     = sscc_pkg::B_IDLE;
			s_next.sda_drv = 1'b0;
			if (s_reg.nv_pend && !s_reg.nv_busy) begin
				s_next.nv_pend = 1'b0;
				s_next.nv_busy = 1'b1;
				s_next.nv_go   = 1'b1;
				s_next.nv_cnt  = '0;
			end
		end else begin
			unique case (s_reg.bus)
				sscc_pkg::B_IDLE: begin
					s_next.sda_drv = 1'b0;
				end
				sscc_pkg::B_ADDR, sscc_pkg::B_REG, sscc_pkg::B_WDATA: begin
					if (scl_rise) begin
						s_next.sh   = {s_reg.sh[6:0], sda};
						s_next.bits = s_reg.bits + 4'h1;
					end else if (scl_fall && s_reg.bits == 4'h8) begin
						s_next.sda_drv = 1'b1;
						if (s_reg.bus == sscc_pkg::B_ADDR) begin
							if (s_reg.sh[7:1] == my_addr && !s_reg.nv_busy) begin
								s_next.bus = sscc_pkg::B_AACK;
								s_next.rw  = s_reg.sh[0];
							end else begin
								s_next.bus     = sscc_pkg::B_IDLE;
								s_next.sda_drv = 1'b0;
							end
						end else if (s_reg.bus == sscc_pkg::B_REG) begin
							s_next.ptr = s_reg.sh;
							s_next.bus = sscc_pkg::B_RGACK;
							if (s_reg.sh == sscc_pkg::CMD_WRITE_NV)
								s_next.nv_pend = 1'b1;
						end else begin
							s_next.bus = sscc_pkg::B_WACK;
							if (s_reg.ptr == sscc_pkg::CMD_PRESCALER)
								s_next.presc = s_reg.sh & sscc_pkg::REG_WMASK;
							if (s_reg.ptr == sscc_pkg::CMD_ADDR)
								s_next.addr = s_reg.sh & sscc_pkg::REG_WMASK;
							if (!s_reg.addr[sscc_pkg::AD_DEFER_BIT])
								s_next.nv_pend = 1'b1;
						end
					end
				end
				sscc_pkg::B_AACK, sscc_pkg::B_RGACK, sscc_pkg::B_WACK, sscc_pkg::B_RACK: begin
					if (scl_rise && s_reg.bus == sscc_pkg::B_RACK)
						s_next.nack = sda;
					if (scl_fall) begin
						s_next.sda_drv = 1'b0;
						s_next.bits    = '0;
						if ((s_reg.bus == sscc_pkg::B_AACK && s_reg.rw)
								|| (s_reg.bus == sscc_pkg::B_RACK && !s_reg.nack)) begin
							s_next.bus     = sscc_pkg::B_RDATA;
							s_next.sh      = {rd[6:0], 1'b1};
							s_next.sda_drv = ~rd[7];
						end else if (s_reg.bus == sscc_pkg::B_RACK) begin
							s_next.bus = sscc_pkg::B_IDLE;
						end else if (s_reg.bus == sscc_pkg::B_AACK) begin
							s_next.bus = sscc_pkg::B_REG;
						end else begin
							s_next.bus = sscc_pkg::B_WDATA;
						end
					end
				end
				sscc_pkg::B_RDATA: begin
					if (scl_fall) begin
						s_next.bits = s_reg.bits + 4'h1;
						if (s_reg.bits == 4'h7) begin
							s_next.sda_drv = 1'b0;
							s_next.bus     = sscc_pkg::B_RACK;
						end else begin
							s_next.sda_drv = ~s_reg.sh[7];
							s_next.sh      = {s_reg.sh[6:0], 1'b1};
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			s_reg <= S_RST;
		else
			s_reg <= s_next;
	end

	assign sda_o            = 1'b0;
	assign sda_oe_o         = s_reg.sda_drv;
	assign clk_out_o        = s_reg.pin_lvl;
	assign clk_out_oe_o     = s_reg.pin_oe;
	assign osc_run_o        = (s_reg.pwr != sscc_pkg::ST_PDN);
	assign nv_write_start_o = s_reg.nv_go;
	assign nv_busy_o        = s_reg.nv_busy;

	AST_DITHER_OFF: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!dith_on |-> (half == 10'(sscc_pkg::MOSC_HALF_CYCLES)))
		else $error("dither active while disabled");
	AST_DITHER_SYM: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(dith_on && p8 == 8'h00) |-> (off == 10'(-{6'd0, amp})))
		else $error("dither low swing wrong");
	AST_PDN_STOP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(s_reg.pwr == sscc_pkg::ST_PDN && $past(s_reg.pwr) == sscc_pkg::ST_PDN) |->
		(!s_reg.osc_lvl && !clk_out_o && !osc_run_o))
		else $error("oscillator or output alive in power-down");
	AST_WARM_LEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(s_reg.pwr == sscc_pkg::ST_RUN) |->
		($past(s_reg.pwr) == sscc_pkg::ST_WARM && $past(s_reg.cnt) == 12'd511))
		else $error("output enabled before settle count");
	AST_POR_LEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		($rose(s_reg.pwr == sscc_pkg::ST_WARM) && $past(s_reg.pwr) == sscc_pkg::ST_POR) |->
		($past(s_reg.cnt) == 12'(sscc_pkg::POR_CYCLES - 1)))
		else $error("start-up delay wrong");
	AST_PDN_DELAY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(s_reg.pwr == sscc_pkg::ST_PDN) |->
		($past(s_reg.pdn_cnt) == 10'(sscc_pkg::PDN_OFF_CYCLES - 1)))
		else $error("power-down entered at wrong time");
	AST_OUT_GATE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(s_reg.pwr != sscc_pkg::ST_RUN) |=> !clk_out_o)
		else $error("output toggling while not running");
	AST_DRIVE_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!s_reg.active && $stable(s_reg.presc)) |->
		(clk_out_oe_o == s_reg.presc[sscc_pkg::PS_DRIVE_LOW_BIT] && !clk_out_o))
		else $error("deactivated output drive wrong");
	AST_DUTY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		($changed(s_reg.out_lvl) && $past(s_reg.pwr) != sscc_pkg::ST_PDN) |->
		($past(osc_edge) && $past(s_reg.div_cnt) >= $past(lim)))
		else $error("output toggled off a divider boundary");
	AST_PRESC_CLAMP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(s_reg.presc[3:0] > 4'h8) |-> (lim == 8'hff))
		else $error("prescaler not clamped");
	AST_NV_AFTER_STOP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		nv_write_start_o |-> ($past(stop) && nv_busy_o))
		else $error("nonvolatile write not started by stop");
	AST_AUTO_NV: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr_take && !s_reg.addr[sscc_pkg::AD_DEFER_BIT]) |=> s_reg.nv_pend)
		else $error("register write did not arm nonvolatile write");
	AST_ADDR_ACK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(s_reg.bus == sscc_pkg::B_AACK) |-> ($past(s_reg.sh[7:1]) == $past(my_addr) && sda_oe_o))
		else $error("acknowledged a foreign address");
endmodule // sscc_top

//--- verif/sscc_i2c_master.sv
// Two-wire bus master model that programs the clock control block
`timescale 1ns/1ps
module sscc_i2c_master #(
	parameter int QTR = 63
) (
	input  wire logic sys_clk_i,
	input  wire logic sda_line_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	// Four quarters of 63 cycles a bit keep SCL just under 400 kHz
	task automatic start();
		sda_low_o = 1'b0;
		tick(QTR);
		scl_o = 1'b1;
		tick(2 * QTR);
		sda_low_o = 1'b1;
		tick(2 * QTR);
		scl_o = 1'b0;
	endtask

	// Returns only after the bus is idle again, so the write time is waited for outside
	task automatic stop();
		tick(QTR);
		sda_low_o = 1'b1;
		tick(QTR);
		scl_o = 1'b1;
		tick(2 * QTR);
		sda_low_o = 1'b0;
		tick(2 * QTR);
	endtask

	// Data only changes while SCL is low and is sampled mid high phase
	task automatic put_bit(input logic b, output logic seen);
		tick(QTR);
		sda_low_o = ~b;
		tick(QTR);
		scl_o = 1'b1;
		tick(QTR);
		seen = sda_line_i;
		tick(QTR);
		scl_o = 1'b0;
	endtask

	// Byte MSB first, then the acknowledge bit; a 1 releases the line
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_seen);
		for (int i = 7; i >= 0; i--)
			put_bit(tx[i], rx[i]);
		put_bit(ack_in, ack_seen);
	endtask
endmodule // sscc_i2c_master

//--- verif/tb_top.sv
// Self-checking testbench of the spread-spectrum clock control block
`timescale 1ns/1ps
module tb_top;
	localparam int NV_CYC = 3000;
	logic sys_clk;
	logic rst_n;
	logic dith;
	logic oe_pin;
	logic pdn_n;
	logic scl;
	logic m_low;
	wire  sda_line;
	wire  sda_oe;
	wire  clk_out;
	wire  clk_out_oe;
	wire  osc_run;
	wire  nv_start;
	wire  nv_busy;
	int   bad_count = 0;
	int   num_checks = 0;
	int   nv_pulses = 0;
	int   rises = 0;
	int   cyc = 0;
	int   busy_len = 0;
	int   hi;
	int   lo;
	int   diff;
	int   outside;
	logic [7:0] rx;
	logic       nak;

	// Open-drain line with pull-up
	assign sda_line = ~(m_low | sda_oe);

	sscc_top #(.NV_WRITE_CYCLES(NV_CYC)) u_dut (
		.sys_clk_i(sys_clk), .rst_n_i(rst_n), .dither_enable_pin_i(dith),
		.output_enable_pin_i(oe_pin), .power_down_pin_n_i(pdn_n), .scl_i(scl),
		.sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe), .clk_out_o(clk_out),
		.clk_out_oe_o(clk_out_oe), .osc_run_o(osc_run), .nv_write_start_o(nv_start),
		.nv_busy_o(nv_busy)
	);

	sscc_i2c_master u_mst (
		.sys_clk_i(sys_clk), .sda_line_i(sda_line), .scl_o(scl), .sda_low_o(m_low)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (rst_n)
			cyc <= cyc + 1;
		if (nv_start === 1'b1)
			nv_pulses <= nv_pulses + 1;
		// Length of the last nonvolatile write, counted from its start pulse
		if (nv_start === 1'b1)
			busy_len <= 1;
		else if (nv_busy === 1'b1)
			busy_len <= busy_len + 1;
	end

	always @(posedge clk_out)
		rises++;

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] dat, input logic ack_exp,
		input logic has_dat);
		u_mst.start();
		u_mst.xfer(8'hb0, 1'b1, rx, nak);
		chk(!nak, ack_exp);
		u_mst.xfer(cmd, 1'b1, rx, nak);
		if (has_dat)
			u_mst.xfer(dat, 1'b1, rx, nak);
		u_mst.stop();
	endtask

	task automatic reg_rd(input logic [7:0] cmd, input logic [7:0] exp);
		u_mst.start();
		u_mst.xfer(8'hb0, 1'b1, rx, nak);
		u_mst.xfer(cmd, 1'b1, rx, nak);
		u_mst.start();
		u_mst.xfer(8'hb1, 1'b1, rx, nak);
		u_mst.xfer(8'hff, 1'b1, rx, nak);
		u_mst.stop();
		chk(rx, exp);
	endtask

	task automatic nv_wait();
		int n;
		n = 0;
		while (nv_busy === 1'b1 && n < 4000) begin
			n++;
			tick(1);
		end
		chk(nv_busy, 1'b0);
		chk(busy_len, NV_CYC);
	endtask

	// Counts settled high and low cycles of one output period
	task automatic meas();
		@(posedge clk_out);
		@(negedge sys_clk);
		hi = 0;
		lo = 0;
		while (clk_out === 1'b1) begin
			hi++;
			@(negedge sys_clk);
		end
		while (clk_out === 1'b0) begin
			lo++;
			@(negedge sys_clk);
		end
	endtask

	initial begin
		repeat (300000) @(posedge sys_clk);
		bad_count++;
		summarize();
	end

	initial begin
		rst_n = 1'b0;
		dith = 1'b0;
		oe_pin = 1'b1;
		pdn_n = 1'b1;
		tick(6);
		rst_n = 1'b1;
		tick(3);
		chk(clk_out_oe, 1'b0);
		reg_wr(8'h02, 8'h41, 1'b1, 1'b1);
		chk(nv_pulses, 1);
		chk(nv_busy, 1'b1);
		reg_wr(8'h02, 8'h00, 1'b0, 1'b1);
		nv_wait();
		chk(nv_pulses, 1);
		reg_rd(8'h02, 8'h41);
		reg_wr(8'h0d, 8'h08, 1'b1, 1'b1);
		chk(nv_pulses, 2);
		nv_wait();
		reg_wr(8'h02, 8'h4f, 1'b1, 1'b1);
		reg_rd(8'h02, 8'h4f);
		reg_wr(8'h02, 8'h51, 1'b1, 1'b1);
		chk(nv_pulses, 2);
		reg_rd(8'h02, 8'h41);
		reg_wr(8'h3f, 8'h00, 1'b1, 1'b0);
		chk(nv_pulses, 3);
		nv_wait();
		u_mst.start();
		u_mst.xfer(8'ha0, 1'b1, rx, nak);
		u_mst.stop();
		chk(nak, 1'b1);
		while (clk_out_oe !== 1'b1 && cyc < 120000)
			tick(1);
		// First master rise comes 100 cycles in, so the 512th rise ends the settle time
		chk(cyc > 4000 + 100 + 511 * 200, 1'b1);
		chk(cyc < 4000 + 513 * 200, 1'b1);
		meas();
		chk(hi, 200);
		chk(lo, 200);
		reg_wr(8'h02, 8'h40, 1'b1, 1'b1);
		meas();
		meas();
		chk(hi, 100);
		reg_wr(8'h0d, 8'hc8, 1'b1, 1'b1);
		dith = 1'b1;
		meas();
		diff = 0;
		outside = 0;
		for (int i = 0; i < 150; i++) begin
			meas();
			if (hi != 100)
				diff++;
			if (hi < 92 || hi > 108 || hi != lo)
				outside++;
		end
		chk(diff > 0, 1'b1);
		chk(outside, 0);
		dith = 1'b0;
		meas();
		meas();
		chk(hi, 100);
		reg_wr(8'h0d, 8'he8, 1'b1, 1'b1);
		chk(clk_out_oe, 1'b1);
		oe_pin = 1'b0;
		tick(600);
		chk(clk_out_oe, 1'b0);
		chk(osc_run, 1'b1);
		reg_wr(8'h02, 8'h60, 1'b1, 1'b1);
		chk(clk_out_oe, 1'b1);
		chk(clk_out, 1'b0);
		reg_wr(8'h0d, 8'hc8, 1'b1, 1'b1);
		meas();
		chk(hi, 100);
		pdn_n = 1'b0;
		tick(650);
		chk(osc_run, 1'b1);
		tick(70);
		chk(osc_run, 1'b0);
		chk(clk_out, 1'b0);
		chk(clk_out_oe, 1'b1);
		pdn_n = 1'b1;
		rises = 0;
		tick(5000);
		chk(osc_run, 1'b1);
		chk(rises, 0);
		summarize();
	end
endmodule // tb_top
